// [src/ast_baud_gen.sv]
/*
 * ast_baud_gen: shared baud divider giving a 16x sample tick.
 * assumes divisor is held steady by the top while the port runs.
 */
`default_nettype none
module ast_baud_gen
   import ast_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic div16,
   input wire logic [15:0] divisor,
   output logic tick
);
   logic [15:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;
   logic [15:0] limit;

   // 8-bit mode ignores the upper divisor byte
   assign limit = div16 ? divisor : {8'h00, divisor[7:0]};
   assign tick = tick_reg;

   always_comb begin
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (!run) begin
         cnt_next = '0;
      end else if (cnt_reg >= limit) begin
         cnt_next = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
endmodule : ast_baud_gen
`default_nettype wire

// [src/ast_fifo.sv]
/*
 * ast_fifo: small parameterised first-in first-out buffer.
 * assumes the user holds data stable while in_valid waits for in_ready.
 */
`default_nettype none
module ast_fifo
   import ast_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   // ************************************************************
   // ***** pointers
   // ************************************************************
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];

   // next pointers wrap explicitly so depth need not be a power of two
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // storage has no reset; only entries counted valid are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule : ast_fifo
`default_nettype wire

// [src/ast_pkg.sv]
/*
 * ast_pkg: shared constants and carrier types for the serial transceiver.
 * assumes a single system clock; all timing is in system clock cycles.
 */
`default_nettype none
package ast_pkg;
   // ************************************************************
   // ***** counts and reset values
   // ************************************************************
   localparam int AST_OVS = 16;          // receive samples per bit
   localparam int AST_OVS_MID = 8;       // sample taken mid-bit
   localparam int AST_BREAK_BITS = 13;   // break length in bit periods
   localparam int AST_ABD_EDGES = 5;     // falling edges of a 0x55 sync
   localparam int AST_ABD_RISE = 5;      // rising edges of a 0x55 sync
   localparam logic [15:0] AST_DIV_RST = 16'h0000;
   localparam logic [1:0] AST_RX_FIFO_DEPTH = 2'h2;

   // ************************************************************
   // ***** carriers
   // ************************************************************
   typedef struct packed {
      logic [8:0] data;     // nine bits, bit 8 unused for 8-bit frames
      logic brk;            // send a 13-bit break instead of data
   } ast_tx_word_t;

   typedef struct packed {
      logic [8:0] data;
      logic frame_err;      // stop bit read at space
   } ast_rx_word_t;

   typedef struct packed {
      logic enable;         // port on (divider, tx, rx, pin enables); wake and auto baud ignore it
      logic tx_en;
      logic rx_en;
      logic nine_bit;
      logic sync_mode;      // half-duplex synchronous
      logic sync_master;
      logic clk_pol;        // clock polarity (sync) / tx invert (async)
      logic div16;          // 16-bit divider, else 8-bit
      logic addr_det;       // drop 9-bit characters whose bit 8 is clear
      logic auto_baud;      // measure next sync character
      logic wake_en;        // wake on any falling edge of the rx line
   } ast_cfg_t;
endpackage : ast_pkg
`default_nettype wire

// [src/ast_top.sv]
/*
 * ast_top: asynchronous / synchronous serial transceiver.
 * assumes control inputs are synchronous to CLK_SYS and held steady
 * while characters are in flight; the pins are resolved by the bench.
 */
`default_nettype none
module ast_top
   import ast_pkg::*;
#(
   parameter int TX_FIFO_DEPTH = 8
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire ast_cfg_t CFG,
   input wire logic [15:0] DIVISOR,
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire ast_tx_word_t TX_WORD,
   output logic RX_VALID,
   input wire logic RX_READY,
   output ast_rx_word_t RX_WORD,
   output logic RX_OVERRUN,
   input wire logic RX_OVERRUN_CLR,
   output logic TX_SHIFT_EMPTY,
   output logic WAKE,
   output logic [15:0] BAUD_MEASURED,
   output logic BAUD_DONE,
   input wire logic CK_IN,
   output logic CK_OUT,
   output logic CK_OE,
   input wire logic DT_IN,
   output logic DT_OUT,
   output logic DT_OE,
   output logic TX_INTERNAL
);
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK} ast_tx_st_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_st_t;

   // ************************************************************
   // ***** baud tick and transmit buffer
   // ************************************************************
   logic tick;
   logic hb_valid, hb_ready;
   logic tx_take;
   ast_tx_word_t hb_word;

   ast_baud_gen u_baud (
      .clk(CLK_SYS),
      .rst(RST),
      .run(CFG.enable),
      .div16(CFG.div16),
      .divisor(DIVISOR),
      .tick(tick)
   );

   // the fifo is the holding buffer, so bursts of up to TX_FIFO_DEPTH do
   // not stall the writer; its head entry loads the shift register directly
   ast_fifo #(.WIDTH($bits(ast_tx_word_t)), .DEPTH(TX_FIFO_DEPTH)) u_txq (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(TX_VALID),
      .in_ready(hb_ready),
      .in_data(TX_WORD),
      .out_valid(hb_valid),
      .out_ready(tx_take),
      .out_data(hb_word)
   );

   // ************************************************************
   // ***** transmitter
   // ************************************************************
   ast_tx_st_t tx_st_reg, tx_st_next;
   logic [8:0] tsr_reg, tsr_next;        // tx_shift_register
   logic [3:0] tx_sub_reg, tx_sub_next;  // 16x ticks within a bit
   logic [3:0] tx_bit_reg, tx_bit_next;
   logic tx_line_reg, tx_line_next;
   logic tx_bit_end;

   assign tx_bit_end = tick && (tx_sub_reg == 4'(AST_OVS-1));
   // a held character is taken on the cycle the stop bit ends; from idle
   // the load waits for a tick so the start bit is not cut short by the
   // free-running divider phase
   assign tx_take = hb_valid && CFG.enable && CFG.tx_en &&
      ((tx_st_reg == TX_IDLE && tick) ||
       (tx_st_reg == TX_STOP && tx_bit_end));

   always_comb begin
      tx_st_next = tx_st_reg;
      tsr_next = tsr_reg;
      tx_sub_next = tx_sub_reg;
      tx_bit_next = tx_bit_reg;
      tx_line_next = tx_line_reg;
      if (tick) begin
         tx_sub_next = tx_sub_reg + 4'h1;
      end
      unique case (tx_st_reg)
         TX_IDLE: begin
            tx_line_next = 1'b1;
         end
         TX_START: begin
            if (tx_bit_end) begin
               tx_st_next = TX_DATA;
               tx_line_next = tsr_reg[0];
               tsr_next = {1'b0, tsr_reg[8:1]};
               tx_bit_next = 4'h1;
            end
         end
         TX_DATA: begin
            if (tx_bit_end) begin
               if (tx_bit_reg == (CFG.nine_bit ? 4'h9 : 4'h8)) begin
                  tx_st_next = TX_STOP;
                  tx_line_next = 1'b1;
               end else begin
                  tx_line_next = tsr_reg[0];
                  tsr_next = {1'b0, tsr_reg[8:1]};
                  tx_bit_next = tx_bit_reg + 4'h1;
               end
            end
         end
         TX_BRK: begin
            if (tx_bit_end) begin
               tx_bit_next = tx_bit_reg + 4'h1;
               if (tx_bit_reg == 4'(AST_BREAK_BITS-1)) begin
                  tx_st_next = TX_STOP;
                  tx_line_next = 1'b1;
               end
            end
         end
         TX_STOP: begin
            if (tx_bit_end) begin
               tx_st_next = TX_IDLE;
            end
         end
      endcase
      // loading restarts the bit timer so the start bit is full length
      if (tx_take) begin
         tsr_next = hb_word.data;
         tx_sub_next = '0;
         tx_bit_next = '0;
         tx_line_next = 1'b0;
         tx_st_next = hb_word.brk ? TX_BRK : TX_START;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         tx_st_reg <= TX_IDLE;
         tsr_reg <= '0;
         tx_sub_reg <= '0;
         tx_bit_reg <= '0;
         tx_line_reg <= 1'b1;
      end else begin
         tx_st_reg <= tx_st_next;
         tsr_reg <= tsr_next;
         tx_sub_reg <= tx_sub_next;
         tx_bit_reg <= tx_bit_next;
         tx_line_reg <= tx_line_next;
      end
   end

   // ************************************************************
   // ***** receiver
   // ************************************************************
   ast_rx_st_t rx_st_reg, rx_st_next;
   logic [8:0] rsr_reg, rsr_next;        // rx_shift_register
   logic [3:0] rx_sub_reg, rx_sub_next;
   logic [3:0] rx_bit_reg, rx_bit_next;
   logic rx_prev_reg, rx_prev_next;
   logic ovr_reg, ovr_next;
   logic rx_push;
   ast_rx_word_t rx_push_word;
   logic rxq_ready;
   logic rx_in;
   logic rx_mid;

   // in sync mode the data pin is shared; async reads the same pin
   assign rx_in = DT_IN;
   assign rx_mid = tick && (rx_sub_reg == 4'(AST_OVS_MID-1));

   always_comb begin
      rx_st_next = rx_st_reg;
      rsr_next = rsr_reg;
      rx_sub_next = rx_sub_reg;
      rx_bit_next = rx_bit_reg;
      rx_prev_next = rx_in;
      ovr_next = ovr_reg && !RX_OVERRUN_CLR;
      rx_push = 1'b0;
      rx_push_word = '0;
      if (tick) begin
         rx_sub_next = rx_sub_reg + 4'h1;
      end
      unique case (rx_st_reg)
         RX_IDLE: begin
            if (CFG.enable && CFG.rx_en && !CFG.sync_mode &&
                rx_prev_reg && !rx_in) begin
               rx_st_next = RX_START;
               rx_sub_next = '0;
            end
         end
         RX_START: begin
            if (rx_mid) begin
               // a glitch shorter than half a bit is ignored
               rx_st_next = rx_in ? RX_IDLE : RX_DATA;
               rx_bit_next = '0;
               rx_sub_next = '0;
            end
         end
         RX_DATA: begin
            if (tick && rx_sub_reg == 4'(AST_OVS-1)) begin
               rsr_next = CFG.nine_bit ? {rx_in, rsr_reg[8:1]}
                                       : {1'b0, rx_in, rsr_reg[7:1]};
               rx_bit_next = rx_bit_reg + 4'h1;
               if (rx_bit_reg == (CFG.nine_bit ? 4'h8 : 4'h7)) begin
                  rx_st_next = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (tick && rx_sub_reg == 4'(AST_OVS-1)) begin
               rx_st_next = RX_IDLE;
               rx_push_word.data = rsr_reg;
               rx_push_word.frame_err = !rx_in;
               // 9-bit address mode keeps only characters with bit 8 set
               if (!(CFG.nine_bit && CFG.addr_det && !rsr_reg[8])) begin
                  rx_push = 1'b1;
                  if (!rxq_ready) begin
                     ovr_next = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rx_st_reg <= RX_IDLE;
         rsr_reg <= '0;
         rx_sub_reg <= '0;
         rx_bit_reg <= '0;
         rx_prev_reg <= 1'b1;
         ovr_reg <= 1'b0;
      end else begin
         rx_st_reg <= rx_st_next;
         rsr_reg <= rsr_next;
         rx_sub_reg <= rx_sub_next;
         rx_bit_reg <= rx_bit_next;
         rx_prev_reg <= rx_prev_next;
         ovr_reg <= ovr_next;
      end
   end

   // two-character receive buffer; a push while full is dropped
   ast_fifo #(.WIDTH($bits(ast_rx_word_t)),
              .DEPTH(int'(AST_RX_FIFO_DEPTH))) u_rxq (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(rx_push),
      .in_ready(rxq_ready),
      .in_data(rx_push_word),
      .out_valid(RX_VALID),
      .out_ready(RX_READY),
      .out_data(RX_WORD)
   );

   // ************************************************************
   // ***** auto baud, wake, pins
   // ************************************************************
   logic [15:0] ab_cnt_reg, ab_cnt_next;
   logic [2:0] ab_fall_reg, ab_fall_next;
   logic ab_done_reg, ab_done_next;
   logic [15:0] ab_val_reg, ab_val_next;
   logic wake_reg, wake_next;
   logic ck_reg, ck_next, ckoe_reg, ckoe_next, dtoe_reg, dtoe_next;
   logic txo_reg, txo_next;

   // sync char 0x55 gives five falling edges spanning eight bits;
   // divisor = cycles / (8 bits * 16 samples) - 1
   always_comb begin
      ab_cnt_next = ab_cnt_reg;
      ab_fall_next = ab_fall_reg;
      ab_done_next = 1'b0;
      ab_val_next = ab_val_reg;
      if (!CFG.auto_baud) begin
         ab_fall_next = '0;
         ab_cnt_next = '0;
      end else begin
         if (ab_fall_reg != 3'h0 && ab_cnt_reg != 16'hffff) begin
            ab_cnt_next = ab_cnt_reg + 16'h0001;
         end
         if (rx_prev_reg && !rx_in) begin
            ab_fall_next = ab_fall_reg + 3'h1;
            if (ab_fall_reg == 3'(AST_ABD_EDGES-1)) begin
               // the count misses the edge cycle itself, so add it back
               ab_val_next = ((ab_cnt_reg + 16'h0001) >> 7) - 16'h0001;
               ab_done_next = 1'b1;
               ab_fall_next = '0;
               ab_cnt_next = '0;
            end
         end
      end
      // wake holds until the line returns to mark after any falling edge
      wake_next = wake_reg;
      if (CFG.wake_en && rx_prev_reg && !rx_in) begin
         wake_next = 1'b1;
      end else if (!CFG.wake_en || rx_in) begin
         wake_next = wake_reg && CFG.wake_en && !rx_in;
      end
      // sync master: clock from tick, data driven only while sending
      ck_next = CFG.clk_pol ^ (CFG.sync_mode && tx_sub_reg[3]);
      ckoe_next = CFG.enable && (!CFG.sync_mode || CFG.sync_master);
      dtoe_next = CFG.enable && CFG.sync_mode && (tx_st_reg != TX_IDLE);
      txo_next = tx_line_reg ^ (CFG.clk_pol && !CFG.sync_mode);
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ab_cnt_reg <= '0;
         ab_fall_reg <= '0;
         ab_done_reg <= 1'b0;
         ab_val_reg <= AST_DIV_RST;
         wake_reg <= 1'b0;
         ck_reg <= 1'b0;
         ckoe_reg <= 1'b0;
         dtoe_reg <= 1'b0;
         txo_reg <= 1'b1;
      end else begin
         ab_cnt_reg <= ab_cnt_next;
         ab_fall_reg <= ab_fall_next;
         ab_done_reg <= ab_done_next;
         ab_val_reg <= ab_val_next;
         wake_reg <= wake_next;
         ck_reg <= ck_next;
         ckoe_reg <= ckoe_next;
         dtoe_reg <= dtoe_next;
         txo_reg <= txo_next;
      end
   end

   // async: tx line on the clock pin; sync: serial data on data pin
   assign CK_OUT = CFG.sync_mode ? ck_reg : txo_reg;
   assign CK_OE = ckoe_reg;
   assign DT_OUT = txo_reg;
   assign DT_OE = dtoe_reg;
   assign TX_INTERNAL = txo_reg;
   assign TX_READY = hb_ready;
   assign RX_OVERRUN = ovr_reg;
   assign TX_SHIFT_EMPTY = (tx_st_reg == TX_IDLE);
   assign WAKE = wake_reg;
   assign BAUD_MEASURED = ab_val_reg;
   assign BAUD_DONE = ab_done_reg;
   // tx and rx machines share only the tick and format
   // no parity logic exists; bit 8 passes through untouched
endmodule : ast_top
`default_nettype wire

// [verification/ast_assertions.sv]
/* ast_assertions: timing checks on the ports of ast_top.
   assumes one clock domain and a divisor held steady in use. */
`default_nettype none
module ast_checker
   import ast_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire ast_cfg_t CFG,
   input wire logic [15:0] DIVISOR,
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic RX_VALID,
   input wire logic RX_READY,
   input wire ast_rx_word_t RX_WORD,
   input wire logic RX_OVERRUN,
   input wire logic RX_OVERRUN_CLR,
   input wire logic TX_SHIFT_EMPTY,
   input wire logic WAKE,
   input wire logic BAUD_DONE,
   input wire logic DT_IN,
   input wire logic TX_INTERNAL
);
   // ********************
   // low run length on the line, in cycles
   // ********************
   int run_reg, run_next, bitc, div;
   // 8-bit divider only sees the low byte
   always_comb div = CFG.div16 ? int'(DIVISOR) : int'(DIVISOR[7:0]);
   always_comb bitc = 16 * (div + 1);
   always_comb run_next = TX_INTERNAL ? 0 : run_reg + 1;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) run_reg <= 0;
      else run_reg <= run_next;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // ********************
   // rules on the ports
   // ********************
   chk_idle_mark:
   assert property (TX_SHIFT_EMPTY && !CFG.clk_pol |-> TX_INTERNAL)
      else $error("line left mark while idle");
   chk_bit_whole:
   assert property ($rose(TX_INTERNAL) |-> run_reg % bitc == 0)
      else $error("low run not whole bit periods");
   chk_break_len:
   assert property ($rose(TX_INTERNAL) && run_reg > 10 * bitc
      |-> run_reg == 13 * bitc) else $error("break length wrong");
   chk_start_lat:
   assert property (TX_VALID && TX_READY && TX_SHIFT_EMPTY && CFG.enable
      && CFG.tx_en && !CFG.sync_mode && !CFG.clk_pol
      |-> ##[1:4] !TX_INTERNAL) else $error("start bit late");
   chk_ovr_sticky:
   assert property (RX_OVERRUN && !RX_OVERRUN_CLR |=> RX_OVERRUN)
      else $error("overrun flag lost");
   chk_rx_hold:
   assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD))
      else $error("receive word dropped");
   chk_wake_rise:
   assert property ($fell(DT_IN) && CFG.wake_en |-> ##[0:4] WAKE)
      else $error("no wake on line low");
   chk_baud_pulse:
   assert property (BAUD_DONE |=> !BAUD_DONE)
      else $error("baud done too long");
   cov_ovr: cover property ($rose(RX_OVERRUN));
   cov_baud: cover property (BAUD_DONE);
   cov_brk: cover property ($rose(TX_INTERNAL) && run_reg > 10 * bitc);
endmodule // ast_checker
bind ast_top ast_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .CFG(CFG),
   .DIVISOR(DIVISOR), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
   .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_WORD(RX_WORD),
   .RX_OVERRUN(RX_OVERRUN), .RX_OVERRUN_CLR(RX_OVERRUN_CLR),
   .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .WAKE(WAKE), .BAUD_DONE(BAUD_DONE),
   .DT_IN(DT_IN), .TX_INTERNAL(TX_INTERNAL));
`default_nettype wire

// [verification/ast_term_model.sv]
/* ast_term_model: far-end terminal on the async line.
   assumes BIT system clocks per bit and a line idling high. */
`default_nettype none
module ast_term_model #(
   parameter int BIT = 32
) (
   input wire logic clk,
   input wire logic nine,
   input wire logic line_in,
   output logic line_out,
   output logic got,
   output logic [9:0] got_word,
   output int low_run
);
   // ********************
   // receive side
   // ********************
   int cnt = 0;
   logic [8:0] d;
   // last low stretch, used to time a break
   always @(posedge clk) begin
      if (line_in === 1'b0) cnt++;
      else begin
         if (cnt != 0) low_run = cnt;
         cnt = 0;
      end
   end
   // sample mid-bit; a break holds the line low past the stop
   initial begin
      got = 1'b0;
      got_word = '0;
      forever begin
         @(posedge clk);
         if (line_in === 1'b0) begin
            repeat (BIT / 2) @(posedge clk);
            d = '0;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (BIT) @(posedge clk);
               d[i] = line_in;
            end
            repeat (BIT) @(posedge clk);
            got_word = {d, line_in};
            @(negedge clk) got = 1'b1;
            @(negedge clk) got = 1'b0;
            while (line_in !== 1'b1) @(posedge clk);
         end
      end
   end
   // ********************
   // send side
   // ********************
   initial line_out = 1'b1;
   // one frame, lsb first; bad puts the stop bit at space
   task automatic send(input logic [8:0] v, input logic bad);
      @(negedge clk) line_out = 1'b0;
      repeat (BIT) @(negedge clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         line_out = v[i];
         repeat (BIT) @(negedge clk);
      end
      line_out = ~bad;
      repeat (BIT) @(negedge clk);
      line_out = 1'b1;
   endtask
endmodule // ast_term_model
`default_nettype wire

// [verification/test_async_serial_transceiver.sv]
/* test_async_serial_transceiver: self-checking bench for ast_top.
   assumes the terminal model decodes the pin and drives the rx line. */
`default_nettype none
module test_async_serial_transceiver
   import ast_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // signals and dut
   // ********************
   localparam int BITC = 32; // 16 ticks of divisor 1
   localparam int LIMIT = 40000;
   logic clk = 1'b0;
   logic rst, tx_valid, tx_ready, rx_valid, rx_ready, ovr, ovr_clr;
   logic sh_empty, wake, baud_done, ck_out, ck_oe, dt_out, dt_oe;
   logic tx_int, rx_line, got, refused;
   logic [15:0] baud_meas;
   logic [9:0] got_word;
   logic [31:0] seed, rseed;
   ast_cfg_t cfg;
   ast_tx_word_t tx_word;
   ast_rx_word_t rx_word;
   int low_run, n_errors = 0, checks = 0, cyc = 0;
   logic [9:0] q_tx[$], q_rx[$];
   always #2 clk = ~clk;
   ast_top dut (.CLK_SYS(clk), .RST(rst), .CFG(cfg), .DIVISOR(16'h0001),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_WORD(tx_word),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_WORD(rx_word),
      .RX_OVERRUN(ovr), .RX_OVERRUN_CLR(ovr_clr), .TX_SHIFT_EMPTY(sh_empty),
      .WAKE(wake), .BAUD_MEASURED(baud_meas), .BAUD_DONE(baud_done),
      .CK_IN(1'b0), .CK_OUT(ck_out), .CK_OE(ck_oe), .DT_IN(rx_line),
      .DT_OUT(dt_out), .DT_OE(dt_oe), .TX_INTERNAL(tx_int));
   ast_term_model #(.BIT(BITC)) term (.clk(clk), .nine(cfg.nine_bit),
      .line_in(ck_out), .line_out(rx_line), .got(got),
      .got_word(got_word), .low_run(low_run));
   // ********************
   // tasks
   // ********************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input logic [9:0] a, input logic [9:0] e);
      checks++;
      if (a !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, a, e);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // queue one character; a refusal shows the fifo full
   task automatic put(input logic [8:0] v, input logic b);
      q_tx.push_back({b ? 9'h0 : cfg.nine_bit ? v : {1'b0, v[7:0]}, ~b});
      @(negedge clk);
      tx_valid = 1'b1;
      tx_word = '{data: v, brk: b};
      do begin
         @(posedge clk);
         if (tx_ready !== 1'b1) refused = 1'b1;
      end while (tx_ready !== 1'b1);
      @(negedge clk) tx_valid = 1'b0;
   endtask
   task automatic rsend(input logic [8:0] v, input logic bad,
                        input logic keep);
      if (keep) q_rx.push_back({cfg.nine_bit ? v : {1'b0, v[7:0]}, bad});
      term.send(v, bad);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 8000; k++) begin
         @(negedge clk);
         if (q_tx.size() == 0 && q_rx.size() == 0 && sh_empty) return;
      end
      n_errors++;
      $display("[ERR] %0t transfer did not finish", $time);
   endtask
   // ********************
   // result watcher and time limit
   // ********************
   always @(posedge clk) begin
      if (got) cmp(got_word, q_tx.pop_front());
      if (rx_valid && rx_ready) cmp(rx_word, q_rx.pop_front());
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_errors++;
         stop_test();
      end
   end
   // ********************
   // main sequence
   // ********************
   initial begin
      rst = 1'b1;
      cfg = '0;
      tx_valid = 1'b0;
      tx_word = '0;
      rx_ready = 1'b1;
      ovr_clr = 1'b0;
      refused = 1'b0;
      seed = 32'h09f1e76c;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      cmp({7'h0, tx_int, dt_oe, ck_oe}, 10'h004);
      cfg.enable = 1'b1;
      cfg.tx_en = 1'b1;
      cfg.rx_en = 1'b1;
      // both directions at once, 8-bit then 9-bit on the 16-bit divider
      for (int m = 0; m < 2; m++) begin
         cfg.nine_bit = m[0];
         cfg.div16 = m[0];
         rseed = lfsr(~seed);
         fork
            for (int i = 0; i < 10; i++) begin
               seed = lfsr(seed);
               put(seed[8:0], 1'b0);
            end
            for (int i = 0; i < 3; i++) begin
               rseed = lfsr(rseed);
               rsend(rseed[8:0], 1'b0, 1'b1);
            end
         join
         wait_idle();
      end
      cmp({9'h0, refused}, 10'h001);
      put(9'h0, 1'b1);
      wait_idle();
      cmp(10'(low_run), 10'(13 * BITC));
      cfg.nine_bit = 1'b0;
      rsend(9'h0a5, 1'b1, 1'b1);
      // third character arrives with both entries full
      rx_ready = 1'b0;
      for (int i = 0; i < 3; i++) rsend(9'h03c + 9'(i), 1'b0, i < 2);
      cmp({9'h0, ovr}, 10'h001);
      rx_ready = 1'b1;
      wait_idle();
      ovr_clr = 1'b1;
      @(negedge clk) ovr_clr = 1'b0;
      @(negedge clk) cmp({9'h0, ovr}, 10'h000);
      cfg.nine_bit = 1'b1;
      cfg.addr_det = 1'b1;
      rsend(9'h012, 1'b0, 1'b0);
      rsend(9'h134, 1'b0, 1'b1);
      wait_idle();
      cfg.addr_det = 1'b0;
      cfg.wake_en = 1'b1;
      fork
         rsend(9'h1f0, 1'b0, 1'b1);
         begin
            repeat (BITC / 2) @(negedge clk);
            cmp({9'h0, wake}, 10'h001);
         end
      join
      wait_idle();
      cfg.wake_en = 1'b0;
      cfg.nine_bit = 1'b0;
      rx_ready = 1'b0;
      cfg.auto_baud = 1'b1;
      // sync character at divisor 1: 8 bits span 256 cycles
      fork
         rsend(9'h055, 1'b0, 1'b0);
         for (int k = 0; k < 12 * BITC && !baud_done; k++) @(posedge clk);
      join
      cmp(baud_meas[9:0], 10'h001);
      @(negedge clk);
      cfg = '0;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      cmp({7'h0, tx_int, dt_oe, ck_oe}, 10'h004);
      stop_test();
   end
endmodule // test_async_serial_transceiver
`default_nettype wire
